// *** hw/smc_pkg.sv ***
package smc_pkg;
  localparam logic [7:0] SMC_CTRL_ADDR    = 8'hdf;
  localparam logic [7:0] SMC_CTRL_RESET   = 8'hde;
  localparam int         SMC_BIT_DGOOD    = 7;
  localparam int         SMC_BIT_AGOOD    = 6;
  localparam int         SMC_BIT_FLAG     = 5;
  localparam int         SMC_BIT_DTRIP_HI = 4;
  localparam int         SMC_BIT_DTRIP_LO = 3;
  localparam int         SMC_BIT_ATRIP_HI = 2;
  localparam int         SMC_BIT_ATRIP_LO = 1;
  localparam int         SMC_BIT_ENABLE   = 0;
  localparam logic [7:0] SMC_WRITE_MASK   = 8'h3f;
  localparam logic [1:0] SMC_TRIP_463     = 2'h0;
  localparam logic [1:0] SMC_TRIP_308     = 2'h1;
  localparam logic [1:0] SMC_TRIP_293     = 2'h2;
  localparam logic [1:0] SMC_TRIP_263     = 2'h3;
  localparam int         SMC_CLOCK_HZ     = 200000000;
  localparam int         SMC_TICK_HZ      = 32768;
  localparam int         SMC_RECOVER_MS   = 250;
  localparam int         SMC_RECOVER_TICKS = SMC_TICK_HZ * SMC_RECOVER_MS / 1000;
  localparam int         SMC_TICK_DIV     = SMC_CLOCK_HZ / SMC_TICK_HZ;
  localparam int         SMC_GLITCH_CYC   = 4;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smc_bus_t;

  typedef struct packed {
    logic [1:0] digitalTrip;
    logic [1:0] analogTrip;
    logic       monitorOn;
  } smc_analog_t;
endpackage

// *** hw/smc_filter.sv ***
`timescale 1ns/100ps
module smc_filter #(
  parameter int LEN = 4
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic rawGood,
  output logic      goodOut
);
  import smc_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic       good;
  } smc_filt_t;
  smc_filt_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (rawGood) begin
      state_next.cnt  = 8'h00;
      state_next.good = 1'b1;
    end else if (state_reg.cnt == 8'(LEN - 1)) begin
      state_next.good = 1'b0;
    end else begin
      state_next.cnt = state_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '{cnt: 8'h00, good: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign goodOut = state_reg.good;

  glitch_held_a: assert property (@(posedge clock) disable iff (!reset_n)
    rawGood ##1 !rawGood |=> goodOut) else $error("single low sample dropped good");
endmodule // smc_filter

// *** hw/smc_supply_monitor.sv ***
`timescale 1ns/100ps
// Functional notes
// - monitoring active only while control bit 0 is one.
// - bits 7 and 6 read live digital and analog comparator states.
// - flag bit 5 sets whenever either filtered rail comparator is low while bit 0 is one.
// - after both rails good, 250 ms recovery count clears the flag.
// - software may write flag but cannot clear it while a rail is low and bit 0 is one.
// - interrupt request goes out only when core enable allows it.
// - bits 4:3 select digital trip point, 00 4.63 V to 11 2.63 V.
// - bits 2:1 select analog trip point with same encoding.
// - comparator glitches are filtered before they can set the flag.
// - monitor interrupt clears the watchdog enable bit.
module smc_supply_monitor #(
  parameter int RECOVER_TICKS = smc_pkg::SMC_RECOVER_TICKS,
  parameter int TICK_DIV      = smc_pkg::SMC_TICK_DIV,
  parameter int GLITCH_CYC    = smc_pkg::SMC_GLITCH_CYC
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire smc_pkg::smc_bus_t  sfrBus,
  output logic [7:0]              sfrReadData,
  input  wire logic               digitalCompare,
  input  wire logic               analogCompare,
  input  wire logic               monitorIntEnable,
  output smc_pkg::smc_analog_t    analogCtrl,
  output logic                    lowSupplyIrq,
  output logic                    watchdogClear
);
  import smc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_LOW     = 3'b010,
    ST_RECOVER = 3'b100
  } smc_state_t;

  typedef struct packed {
    smc_state_t  fsm;
    logic [7:0]  ctrl;
    logic [15:0] divCnt;
    logic [15:0] recCnt;
    logic        dGood;
    logic        aGood;
  } smc_regs_t;

  smc_regs_t state_reg, state_next;
  logic      dFilt;
  logic      aFilt;
  logic      bothGood;
  logic      tick;
  logic      flagNow;
  logic      sfrHit;
  logic      recExpire;

  function automatic logic smc_hit(input smc_bus_t b);
    return b.write && (b.addr == SMC_CTRL_ADDR);
  endfunction

  smc_filter #(.LEN(GLITCH_CYC)) filtD (
    .clock   (clock),
    .reset_n (reset_n),
    .rawGood (digitalCompare),
    .goodOut (dFilt)
  );
  smc_filter #(.LEN(GLITCH_CYC)) filtA (
    .clock   (clock),
    .reset_n (reset_n),
    .rawGood (analogCompare),
    .goodOut (aFilt)
  );

  assign bothGood = dFilt && aFilt;
  assign tick     = (state_reg.divCnt == 16'(TICK_DIV - 1));
  assign sfrHit   = smc_hit(sfrBus);
  // last tick of an unbroken recovery with both filtered rails good
  assign recExpire = state_reg.ctrl[SMC_BIT_ENABLE] && (state_reg.fsm == ST_RECOVER) && bothGood
                     && tick && (state_reg.recCnt == 16'(RECOVER_TICKS - 1));

  always_comb begin
    state_next = state_reg;
    state_next.dGood = digitalCompare;
    state_next.aGood = analogCompare;
    state_next.divCnt = tick ? 16'h0000 : state_reg.divCnt + 16'h0001;
    if (sfrHit) begin
      state_next.ctrl = (state_reg.ctrl & ~SMC_WRITE_MASK) | (sfrBus.wdata & SMC_WRITE_MASK);
      if (!sfrBus.wdata[SMC_BIT_FLAG] && !bothGood && state_reg.ctrl[SMC_BIT_ENABLE]) begin
        state_next.ctrl[SMC_BIT_FLAG] = 1'b1;
      end
    end
    if (!state_reg.ctrl[SMC_BIT_ENABLE]) begin
      state_next.fsm    = ST_IDLE;
      state_next.recCnt = 16'h0000;
    end else begin
      case (state_reg.fsm)
        ST_IDLE: begin
          if (!bothGood) begin
            state_next.fsm = ST_LOW;
          end
        end
        ST_LOW: begin
          state_next.recCnt = 16'h0000;
          if (bothGood) begin
            state_next.fsm    = ST_RECOVER;
            // restart the divider so the first tick is a whole period
            state_next.divCnt = 16'h0000;
          end
        end
        ST_RECOVER: begin
          if (!bothGood) begin
            state_next.fsm    = ST_LOW;
            state_next.recCnt = 16'h0000;
          end else if (tick) begin
            if (recExpire) begin
              state_next.fsm                = ST_IDLE;
              state_next.recCnt             = 16'h0000;
              state_next.ctrl[SMC_BIT_FLAG] = 1'b0;
            end else begin
              state_next.recCnt = state_reg.recCnt + 16'h0001;
            end
          end
        end
        default: begin
          state_next.fsm = ST_IDLE;
        end
      endcase
      if (!bothGood) begin
        state_next.ctrl[SMC_BIT_FLAG] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= '{fsm: ST_IDLE, ctrl: SMC_CTRL_RESET & SMC_WRITE_MASK, divCnt: 16'h0000,
                     recCnt: 16'h0000, dGood: 1'b1, aGood: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign flagNow = state_reg.ctrl[SMC_BIT_FLAG];

  always_comb begin
    sfrReadData                = state_reg.ctrl;
    sfrReadData[SMC_BIT_DGOOD] = state_reg.dGood;
    sfrReadData[SMC_BIT_AGOOD] = state_reg.aGood;
  end

  assign analogCtrl.digitalTrip = state_reg.ctrl[SMC_BIT_DTRIP_HI:SMC_BIT_DTRIP_LO];
  assign analogCtrl.analogTrip  = state_reg.ctrl[SMC_BIT_ATRIP_HI:SMC_BIT_ATRIP_LO];
  assign analogCtrl.monitorOn   = state_reg.ctrl[SMC_BIT_ENABLE];
  assign lowSupplyIrq  = flagNow && monitorIntEnable;
  assign watchdogClear = lowSupplyIrq;

  // rail events and interrupt path
  flag_sets_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg.ctrl[SMC_BIT_ENABLE] && !bothGood) |=> flagNow) else $error("flag not set on low rail");
  no_sw_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (flagNow && !bothGood && state_reg.ctrl[SMC_BIT_ENABLE]) |=> flagNow) else $error("flag cleared while low");
  clear_timing_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($fell(flagNow) && !$past(sfrHit)) |-> $past(recExpire))
    else $error("flag cleared without recovery expiry");
  restart_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg.fsm == ST_RECOVER && !bothGood && state_reg.ctrl[SMC_BIT_ENABLE]) |=> state_reg.recCnt == 16'h0000)
    else $error("recovery did not restart");
  irq_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    lowSupplyIrq == (flagNow && monitorIntEnable)) else $error("irq gating wrong");
  wdog_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    lowSupplyIrq |-> watchdogClear) else $error("watchdog not cleared");
  live_bits_a: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 sfrReadData[SMC_BIT_DGOOD] == $past(digitalCompare)) else $error("digital bit stale");
  trip_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    sfrHit |=> analogCtrl.digitalTrip == $past(sfrBus.wdata[SMC_BIT_DTRIP_HI:SMC_BIT_DTRIP_LO]))
    else $error("digital trip not written");
  disable_a: assert property (@(posedge clock) disable iff (!reset_n)
    !state_reg.ctrl[SMC_BIT_ENABLE] |=> state_reg.fsm == ST_IDLE) else $error("fsm active while disabled");

  // register view and trip outputs
  analog_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 sfrReadData[SMC_BIT_AGOOD] == $past(analogCompare)) else $error("analog bit stale");
  analog_trip_a: assert property (@(posedge clock) disable iff (!reset_n)
    sfrHit |=> analogCtrl.analogTrip == $past(sfrBus.wdata[SMC_BIT_ATRIP_HI:SMC_BIT_ATRIP_LO]))
    else $error("analog trip not written");
  enable_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    sfrHit |=> analogCtrl.monitorOn == $past(sfrBus.wdata[SMC_BIT_ENABLE]))
    else $error("enable bit not written");
  trip_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !sfrHit |=> $stable(analogCtrl)) else $error("trip outputs moved without a write");
  sw_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (sfrHit && (bothGood || !state_reg.ctrl[SMC_BIT_ENABLE]) && !recExpire)
    |=> flagNow == $past(sfrBus.wdata[SMC_BIT_FLAG])) else $error("flag write lost");

  // flag set and recovery timing
  quiet_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    (bothGood && !flagNow && !sfrHit) |=> !flagNow) else $error("flag set without filtered low");
  low_enter_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg.ctrl[SMC_BIT_ENABLE] && state_reg.fsm == ST_IDLE && !bothGood) |=> state_reg.fsm == ST_LOW)
    else $error("low state not entered");
  rec_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg.ctrl[SMC_BIT_ENABLE] && state_reg.fsm == ST_LOW && bothGood)
    |=> (state_reg.fsm == ST_RECOVER && state_reg.divCnt == 16'h0000)) else $error("recovery start wrong");
  expire_clears_a: assert property (@(posedge clock) disable iff (!reset_n)
    recExpire |=> !flagNow) else $error("flag kept after recovery expiry");
  rec_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_reg.recCnt < 16'(RECOVER_TICKS)) else $error("recovery count out of range");
  div_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_reg.divCnt < 16'(TICK_DIV)) else $error("tick divider out of range");
  fsm_onehot_a: assert property (@(posedge clock) disable iff (!reset_n)
    $onehot(state_reg.fsm)) else $error("state code not one-hot");
  irq_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    !monitorIntEnable |-> !lowSupplyIrq) else $error("irq raised while disabled in core");

  // scenario coverage
  cov_low_c: cover property (@(posedge clock) disable iff (!reset_n) $rose(flagNow));
  cov_rec_c: cover property (@(posedge clock) disable iff (!reset_n) $fell(flagNow));
  cov_irq_c: cover property (@(posedge clock) disable iff (!reset_n) lowSupplyIrq);
  cov_restart_c: cover property (@(posedge clock) disable iff (!reset_n)
    state_reg.fsm == ST_RECOVER ##1 state_reg.fsm == ST_LOW);
  cov_refuse_c: cover property (@(posedge clock) disable iff (!reset_n)
    sfrHit && !sfrBus.wdata[SMC_BIT_FLAG] && flagNow && !bothGood);
endmodule // smc_supply_monitor

// *** tb/smc_rail_model.sv ***
`timescale 1ns/100ps
module smc_rail_model (
  input  wire logic clock,
  input  wire logic railLow,
  output logic      compareOut
);
  // comparator output settles one clock after the rail moves
  always_ff @(posedge clock) begin
    compareOut <= !railLow;
  end
endmodule // smc_rail_model

// *** tb/smc_supply_monitor_tb.sv ***
`timescale 1ns/100ps
module smc_supply_monitor_tb;
  import smc_pkg::*;
  logic        clock = 0, reset_n = 0, irqEn = 0, dLow = 0, aLow = 0, dCmp, aCmp, irq, wdc;
  smc_bus_t    bus = '0;
  smc_analog_t actl;
  logic [7:0]  rd;
  int          err_total = 0, total_checks = 0;

  initial forever #2.5 clock = ~clock;

  smc_rail_model dRail_u (.clock(clock), .railLow(dLow), .compareOut(dCmp));
  smc_rail_model aRail_u (.clock(clock), .railLow(aLow), .compareOut(aCmp));
  smc_supply_monitor #(.RECOVER_TICKS(4), .TICK_DIV(4), .GLITCH_CYC(4)) dut_u (
    .clock(clock), .reset_n(reset_n), .sfrBus(bus), .sfrReadData(rd), .digitalCompare(dCmp),
    .analogCompare(aCmp), .monitorIntEnable(irqEn), .analogCtrl(actl), .lowSupplyIrq(irq),
    .watchdogClear(wdc));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) bus <= '{write: 1'b1, addr: a, wdata: d};
    @(posedge clock) bus.write <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic final_report;
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    final_report;
  end

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    cyc(1);
    chk(rd, SMC_CTRL_RESET);
    wr(8'hde, 8'h3f);
    cyc(1);
    chk(rd, SMC_CTRL_RESET);
    for (int c = 0; c < 4; c++) begin
      wr(SMC_CTRL_ADDR, {3'h0, c[1:0], c[1:0], 1'b1});
      cyc(1);
      chk({3'h0, actl}, {3'h0, c[1:0], c[1:0], 1'b1});
    end
    chk(rd, 8'hdf);
    // short analog dip must be filtered out
    @(posedge clock) aLow <= 1'b1;
    repeat (2) @(posedge clock);
    aLow <= 1'b0;
    cyc(10);
    chk({7'h0, rd[5]}, 8'h0);
    @(posedge clock) begin
      dLow <= 1'b1;
      irqEn <= 1'b1;
    end
    cyc(12);
    chk(rd, 8'h7f);
    chk({6'h0, irq, wdc}, 8'h3);
    @(posedge clock) irqEn <= 1'b0;
    cyc(1);
    chk({6'h0, irq, wdc}, 8'h0);
    wr(SMC_CTRL_ADDR, 8'h1f);
    cyc(2);
    chk({7'h0, rd[5]}, 8'h1);
    // recovery, interrupted once by a real drop
    @(posedge clock) dLow <= 1'b0;
    cyc(8);
    chk({7'h0, rd[5]}, 8'h1);
    @(posedge clock) dLow <= 1'b1;
    repeat (6) @(posedge clock);
    dLow <= 1'b0;
    cyc(12);
    chk({7'h0, rd[5]}, 8'h1);
    cyc(30);
    chk(rd, 8'hdf);
    // monitor off: a low rail leaves the flag alone, software owns it
    wr(SMC_CTRL_ADDR, 8'h1e);
    @(posedge clock) dLow <= 1'b1;
    cyc(12);
    chk(rd, 8'h5e);
    wr(SMC_CTRL_ADDR, 8'h3e);
    cyc(1);
    chk(rd, 8'h7e);
    // rails good again: a clear is accepted, then a long analog drop sets the flag
    @(posedge clock) dLow <= 1'b0;
    cyc(4);
    wr(SMC_CTRL_ADDR, 8'h1f);
    cyc(1);
    chk(rd, 8'hdf);
    @(posedge clock) aLow <= 1'b1;
    cyc(12);
    chk(rd, 8'hbf);
    final_report;
  end
endmodule // smc_supply_monitor_tb
